/* verilog/isp_pkg.sv */
/*
  Shared constants for the serial in-system programming port: instruction
  opcodes, byte counts, echo value, erased value and busy-time figures.
  Assumes a 250 MHz core clock; times are kept in microseconds.
*/
package isp_pkg;
  // Core clock rate in kHz, used to turn times into cycle counts
  localparam int unsigned CLK_KHZ = 250000;
  // Bits per byte and bytes per instruction
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned INSTR_BYTES = 4;
  // Enable instruction bytes
  localparam logic [7:0] OP_PROG_EN = 8'hAC;
  localparam logic [7:0] EN_ECHO = 8'h53;
  localparam logic [7:0] SUB_CHIP_ERASE = 8'h80;
  // Remaining opcodes
  localparam logic [7:0] OP_POLL = 8'hF0;
  localparam logic [7:0] OP_LOAD_EXT = 8'h4D;
  localparam logic [7:0] OP_LOAD_HI = 8'h48;
  localparam logic [7:0] OP_LOAD_LO = 8'h40;
  localparam logic [7:0] OP_READ_HI = 8'h28;
  localparam logic [7:0] OP_READ_LO = 8'h20;
  localparam logic [7:0] OP_READ_EE = 8'hA0;
  localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
  localparam logic [7:0] OP_WRITE_EE = 8'hC0;
  // Value of an erased location
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Busy times in microseconds
  localparam int unsigned FLASH_PAGE_WAIT_US = 4500;
  localparam int unsigned EEPROM_BYTE_WAIT_US = 3600;
  localparam int unsigned CHIP_ERASE_WAIT_US = 9000;
  // Busy times in core cycles
  localparam int unsigned FLASH_PAGE_WAIT_CYC = FLASH_PAGE_WAIT_US * (CLK_KHZ / 1000);
  localparam int unsigned EEPROM_BYTE_WAIT_CYC = EEPROM_BYTE_WAIT_US * (CLK_KHZ / 1000);
  localparam int unsigned CHIP_ERASE_WAIT_CYC = CHIP_ERASE_WAIT_US * (CLK_KHZ / 1000);
endpackage : isp_pkg

/* verilog/isp_link_shifter.sv */
/*
  Link-side shifter on the programmer's serial clock. Samples data in on the
  rising edge, shifts data out on the falling edge, and hands each whole
  byte to the core by a toggle. Assumes the serial clock only runs while
  the chip is held in reset and that the reply byte is stable while shifted.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_link_shifter (
  // Link clock and hold
  input wire logic sck_i,
  input wire logic hold_i,
  // Serial pins
  input wire logic serial_prog_data_in_i,
  output logic serial_prog_data_out_o,
  // Byte to and from the core
  input wire logic [7:0] reply_byte_i,
  output logic [7:0] rx_byte_o,
  output logic rx_toggle_o
);
  // Bits gathered so far and the count
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  // Outgoing byte being shifted
  logic [7:0] tx_reg;

  // Capture on the rising edge, MSB first; the serial clock stands still
  // outside frames, so the hold clears this state without waiting for it
  always_ff @(posedge sck_i or negedge hold_i) begin // [RL4] [RL20]
    if (!hold_i) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      rx_toggle_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= {shift_reg[5:0], serial_prog_data_in_i};
      if (bit_cnt_reg == 3'h7) begin
        // Byte complete: publish and flip the toggle
        rx_byte_o <= {shift_reg, serial_prog_data_in_i};
        rx_toggle_o <= ~rx_toggle_o;
      end
    end
  end

  // Drive out on the falling edge; load the reply at each byte start
  always_ff @(negedge sck_i or negedge hold_i) begin // [RL4]
    if (!hold_i) begin
      tx_reg <= 8'h00;
    end else if (bit_cnt_reg == 3'h0) begin
      tx_reg <= reply_byte_i;
    end else begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Output bit is the head of the outgoing byte
  assign serial_prog_data_out_o = tx_reg[7];
endmodule : isp_link_shifter
`default_nettype wire

/* verilog/serial_isp_programming_port.sv */
/*
  Serial in-system programming port: decodes four-byte instructions from
  the link shifter, keeps the enable state, extended address, flash page
  buffer and busy timer, and drives a simple memory port for the arrays.
  Assumes the memory answers reads in the same core cycle (combinational
  read data) and that the reset pin is asynchronous to the core clock.
*/
//
// Notes on behaviour
// RL1 - Programming works only while reset pin low
// RL2 - Instructions rejected until programming enable seen
// RL3 - Programmer keeps serial clock phases long enough
// RL4 - Sample data on rise, drive on fall
// RL5 - Programmer holds reset and clock low
// RL6 - Programmer waits 20 ms before enable
// RL7 - Echo 0x53 during third enable byte
// RL8 - Programmer pulses reset when echo missing
// RL9 - Page load carries 7 address bits, byte
// RL10 - Programmer loads low byte before high
// RL11 - Page write uses bits 15:8 plus extended; code uses bits 15:PW (15:7 at 128 words) plus extended
// RL12 - Extended address byte kept until reloaded
// RL13 - Programmer waits 4.5 ms after page write
// RL14 - EEPROM byte write self-timed with erase
// RL15 - No chip erase needed before EEPROM write
// RL16 - Chip erase sets both arrays to FF
// RL17 - Reads return addressed byte, flash uses extended
// RL18 - Reset high ends programming mode
// RL19 - Poll returns one in LSB while busy
// RL20 - Bytes MSB first, eight bits, four bytes
`timescale 1ns/1ps
`default_nettype none
module serial_isp_programming_port #(
  parameter int unsigned FLASH_PAGE_WAIT = isp_pkg::FLASH_PAGE_WAIT_CYC,
  parameter int unsigned EEPROM_BYTE_WAIT = isp_pkg::EEPROM_BYTE_WAIT_CYC,
  parameter int unsigned CHIP_ERASE_WAIT = isp_pkg::CHIP_ERASE_WAIT_CYC,
  parameter int unsigned PAGE_WORDS = 128
) (
  // Core clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Chip reset pin, low holds the part in programming
  input wire logic chip_reset_n_i,
  // Serial link
  input wire logic sck_i,
  input wire logic serial_prog_data_in_i,
  output logic serial_prog_data_out_o,
  // Status
  output logic prog_mode_o,
  output logic op_pending_flag_o,
  output logic run_o,
  // Flash memory port
  output logic flash_wr_o,
  output logic [23:0] flash_addr_o,
  output logic [15:0] flash_wdata_o,
  input wire logic [15:0] flash_rdata_i,
  // EEPROM memory port
  output logic ee_wr_o,
  output logic [11:0] ee_addr_o,
  output logic [7:0] ee_wdata_o,
  input wire logic [7:0] ee_rdata_i,
  // Whole-array erase strobe
  output logic erase_all_o
);
  // Widths derived from the page size and the erase wait
  localparam int unsigned PW = $clog2(PAGE_WORDS);
  localparam int unsigned TW = $clog2(CHIP_ERASE_WAIT + 1);

  // Parameter checks, refused at elaboration
  if (PAGE_WORDS < 2 || PAGE_WORDS > 128) begin : g_bad_page
    $error("PAGE_WORDS must be 2 to 128");
  end
  if (FLASH_PAGE_WAIT > CHIP_ERASE_WAIT ||
      EEPROM_BYTE_WAIT > CHIP_ERASE_WAIT) begin : g_bad_wait
    $error("CHIP_ERASE_WAIT must be the longest wait");
  end

  // Write sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FLASH = 2'b01,
    ST_ERASE = 2'b10
  } wstate_t;

  // Reset pin synchroniser
  logic rstpin_meta_reg;
  logic rstpin_sync_reg;
  // Link byte crossing
  logic [7:0] link_byte;
  logic link_toggle;
  logic [1:0] tog_sync_reg;
  logic tog_seen_reg;
  logic byte_stb;
  // Instruction assembly
  logic [1:0] byte_idx_reg;
  logic [7:0] b1_reg;
  logic [7:0] b2_reg;
  logic [7:0] b3_reg;
  logic [7:0] reply_reg;
  logic [7:0] reply_next;
  // Programming state
  logic enabled_reg;
  logic [7:0] ext_addr_reg;
  logic [15:0] page_buf_reg [PAGE_WORDS];
  logic [TW-1:0] busy_cnt_reg;
  logic busy;
  wstate_t wstate_reg;
  logic [PW-1:0] copy_idx_reg;
  logic [15:0] page_hi_reg;
  // Completed instruction
  logic instr_done;
  logic [7:0] b4_in;
  logic hold;

  // Link held active only while the reset pin is low
  assign hold = ~chip_reset_n_i; // [RL1]

  // Link-side shifter on the serial clock
  isp_link_shifter u_link (
    .sck_i(sck_i),
    .hold_i(hold),
    .serial_prog_data_in_i(serial_prog_data_in_i),
    .serial_prog_data_out_o(serial_prog_data_out_o),
    .reply_byte_i(reply_reg),
    .rx_byte_o(link_byte),
    .rx_toggle_o(link_toggle)
  );

  // Two-stage sync of the reset pin
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rstpin_meta_reg <= 1'b1;
      rstpin_sync_reg <= 1'b1;
    end else begin
      rstpin_meta_reg <= chip_reset_n_i;
      rstpin_sync_reg <= rstpin_meta_reg;
    end
  end

  // Toggle crossing of completed bytes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tog_sync_reg <= 2'b00;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[0], link_toggle};
      tog_seen_reg <= tog_sync_reg[1];
    end
  end

  // One pulse per byte; byte data is stable well before the toggle lands
  assign byte_stb = (tog_sync_reg[1] != tog_seen_reg) && !rstpin_sync_reg;
  assign instr_done = byte_stb && (byte_idx_reg == 2'd3);
  assign b4_in = link_byte;
  assign busy = (busy_cnt_reg != '0);

  // Byte position and stored bytes of the instruction
  always_ff @(posedge ref_clk_i) begin // [RL20]
    if (!rst_n_i || rstpin_sync_reg) begin
      byte_idx_reg <= 2'd0;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
    end else if (byte_stb) begin
      byte_idx_reg <= byte_idx_reg + 2'd1;
      case (byte_idx_reg)
        2'd0: b1_reg <= link_byte;
        2'd1: b2_reg <= link_byte;
        2'd2: b3_reg <= link_byte;
        default: ;
      endcase
    end
  end

  // Reply for the next byte to be shifted out
  always_comb begin
    reply_next = reply_reg;
    if (byte_stb) begin
      reply_next = 8'h00;
      case (byte_idx_reg)
        // After byte 2: echo it while byte 3 shifts
        2'd1: reply_next = link_byte; // [RL7]
        // After byte 3: prepare data for byte 4
        2'd2: begin
          if (b1_reg == isp_pkg::OP_POLL) begin
            reply_next = {7'h00, busy}; // [RL19]
          end else if (enabled_reg && !busy) begin // [RL2]
            case (b1_reg)
              isp_pkg::OP_READ_LO: reply_next = flash_rdata_i[7:0]; // [RL17]
              isp_pkg::OP_READ_HI: reply_next = flash_rdata_i[15:8]; // [RL17]
              isp_pkg::OP_READ_EE: reply_next = ee_rdata_i; // [RL17]
              default: reply_next = 8'h00;
            endcase
          end
        end
        default: reply_next = 8'h00;
      endcase
    end
  end

  // Reply register, cleared outside programming
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || rstpin_sync_reg) begin
      reply_reg <= 8'h00;
    end else begin
      reply_reg <= reply_next;
    end
  end

  // Read address: byte 2/3 of the current instruction, valid in byte 3 slot
  always_comb begin
    flash_addr_o = {ext_addr_reg, b2_reg, link_byte}; // [RL17]
    ee_addr_o = {b2_reg[3:0], link_byte};
    if (wstate_reg == ST_FLASH) begin
      // Page write address: extended byte, bits 15:PW, word index
      flash_addr_o = {ext_addr_reg, page_hi_reg[15:PW], copy_idx_reg}; // [RL11]
    end else if (ee_wr_o) begin
      ee_addr_o = {b2_reg[3:0], b3_reg};
    end
  end

  // Programming enable: set by a valid enable, cleared by reset high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || rstpin_sync_reg) begin
      enabled_reg <= 1'b0; // [RL18]
    end else if (instr_done && b1_reg == isp_pkg::OP_PROG_EN && b2_reg == isp_pkg::EN_ECHO) begin
      enabled_reg <= 1'b1; // [RL2]
    end
  end

  // Extended address byte; survives until loaded again
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_addr_reg <= 8'h00;
    end else if (instr_done && enabled_reg && !busy && b1_reg == isp_pkg::OP_LOAD_EXT) begin
      ext_addr_reg <= b3_reg; // [RL12]
    end
  end

  // Page buffer loads, one byte per instruction at 7 address bits
  generate
    for (genvar w = 0; w < PAGE_WORDS; w++) begin : g_page
      always_ff @(posedge ref_clk_i) begin // [RL9]
        if (!rst_n_i) begin
          page_buf_reg[w] <= 16'hFFFF;
        end else if (instr_done && enabled_reg && !busy && b3_reg[PW-1:0] == PW'(w)) begin
          if (b1_reg == isp_pkg::OP_LOAD_LO) begin
            page_buf_reg[w][7:0] <= b4_in;
          end else if (b1_reg == isp_pkg::OP_LOAD_HI) begin
            page_buf_reg[w][15:8] <= b4_in;
          end
        end
      end
    end
  endgenerate

  // Write sequencer: page copy and chip erase
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wstate_reg <= ST_IDLE;
      copy_idx_reg <= '0;
      page_hi_reg <= 16'h0000;
    end else begin
      case (wstate_reg)
        ST_IDLE: begin
          if (instr_done && enabled_reg && !busy) begin // [RL2]
            if (b1_reg == isp_pkg::OP_WRITE_PAGE) begin
              page_hi_reg <= {b2_reg, b3_reg}; // [RL11]
              copy_idx_reg <= '0;
              wstate_reg <= ST_FLASH;
            end else if (b1_reg == isp_pkg::OP_PROG_EN && b2_reg == isp_pkg::SUB_CHIP_ERASE) begin
              wstate_reg <= ST_ERASE; // [RL16]
            end
          end
        end
        ST_FLASH: begin
          // Copy one word a cycle into the array
          copy_idx_reg <= copy_idx_reg + PW'(1);
          if (copy_idx_reg == PW'(PAGE_WORDS - 1)) begin
            wstate_reg <= ST_IDLE;
          end
        end
        ST_ERASE: wstate_reg <= ST_IDLE;
        default: wstate_reg <= ST_IDLE;
      endcase
    end
  end

  // Memory strobes
  assign flash_wr_o = (wstate_reg == ST_FLASH);
  assign flash_wdata_o = page_buf_reg[copy_idx_reg];
  assign erase_all_o = (wstate_reg == ST_ERASE); // [RL16]
  // EEPROM byte written directly; the array erases the cell itself
  assign ee_wr_o = instr_done && enabled_reg && !busy && (b1_reg == isp_pkg::OP_WRITE_EE); // [RL14] [RL15]
  assign ee_wdata_o = b4_in;

  // Busy timer for self-timed operations
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || rstpin_sync_reg) begin
      busy_cnt_reg <= '0;
    end else if (ee_wr_o) begin
      busy_cnt_reg <= TW'(EEPROM_BYTE_WAIT); // [RL14]
    end else if (wstate_reg == ST_IDLE && instr_done && enabled_reg && !busy && b1_reg == isp_pkg::OP_WRITE_PAGE) begin
      busy_cnt_reg <= TW'(FLASH_PAGE_WAIT);
    end else if (wstate_reg == ST_IDLE && instr_done && enabled_reg && !busy && b1_reg == isp_pkg::OP_PROG_EN && b2_reg == isp_pkg::SUB_CHIP_ERASE) begin
      busy_cnt_reg <= TW'(CHIP_ERASE_WAIT); // [RL16]
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg - TW'(1);
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prog_mode_o <= 1'b0;
      op_pending_flag_o <= 1'b0;
      run_o <= 1'b0;
    end else begin
      prog_mode_o <= enabled_reg;
      op_pending_flag_o <= busy; // [RL19]
      run_o <= rstpin_sync_reg; // [RL18]
    end
  end
endmodule : serial_isp_programming_port
`default_nettype wire

/* verification/isp_port_chk.sv */
/*
  Checker for the programming port: write strobes, busy span and exit.
  Assumes a bind to the port top, with its busy parameters handed on.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_port_chk #(
  parameter int unsigned FLASH_PAGE_WAIT = 1,
  parameter int unsigned EEPROM_BYTE_WAIT = 1,
  parameter int unsigned CHIP_ERASE_WAIT = 1,
  parameter int unsigned PAGE_WORDS = 128
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Status
  input wire logic prog_mode_o,
  input wire logic op_pending_flag_o,
  input wire logic run_o,
  // Write strobes
  input wire logic flash_wr_o,
  input wire logic ee_wr_o,
  input wire logic erase_all_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Busy run length, page words per busy span, busy one cycle ago
  int unsigned bsy_cnt;
  int unsigned wr_cnt;
  logic bsy_q;
  // Count busy cycles and words written since the last busy end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bsy_cnt <= 0;
      wr_cnt <= 0;
      bsy_q <= 1'b0;
    end else begin
      bsy_q <= op_pending_flag_o;
      bsy_cnt <= op_pending_flag_o ? bsy_cnt + 1 : 0;
      if (bsy_q && !op_pending_flag_o) begin
        wr_cnt <= flash_wr_o ? 1 : 0;
      end else if (flash_wr_o) begin
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
  // Reset pin held high for a while
  sequence s_run_steady;
    run_o [*3];
  endsequence
  chk_flash_mode: assert property (flash_wr_o |-> prog_mode_o)
    else $error("flash write outside programming mode");
  chk_ee_mode: assert property ((ee_wr_o || erase_all_o) |-> prog_mode_o)
    else $error("eeprom write or erase outside programming mode");
  chk_no_run_wr: assert property ((flash_wr_o || ee_wr_o || erase_all_o) |-> !run_o)
    else $error("array written during normal operation");
  chk_ee_single: assert property (ee_wr_o |=> !ee_wr_o)
    else $error("eeprom strobe longer than one cycle");
  chk_ee_busy: assert property (ee_wr_o |-> ##[0:2] op_pending_flag_o)
    else $error("eeprom write did not raise busy");
  chk_erase_busy: assert property (erase_all_o |-> ##[0:2] op_pending_flag_o)
    else $error("erase did not raise busy");
  chk_run_exit: assert property (s_run_steady |-> !prog_mode_o)
    else $error("programming mode kept after reset pin high");
  chk_busy_bound: assert property (bsy_cnt <= CHIP_ERASE_WAIT + PAGE_WORDS + 16)
    else $error("busy lasted too long");
  chk_page_words: assert property ((bsy_q && !op_pending_flag_o) |-> (wr_cnt == 0 || wr_cnt == PAGE_WORDS))
    else $error("page copy word count wrong");
  chk_busy_hold: assert property ($rose(op_pending_flag_o) |=> op_pending_flag_o [*8])
    else $error("busy dropped too early");
endmodule : isp_port_chk
bind serial_isp_programming_port isp_port_chk #(
  .FLASH_PAGE_WAIT(FLASH_PAGE_WAIT),
  .EEPROM_BYTE_WAIT(EEPROM_BYTE_WAIT),
  .CHIP_ERASE_WAIT(CHIP_ERASE_WAIT),
  .PAGE_WORDS(PAGE_WORDS)
) i_isp_port_chk (
  .ref_clk_i, .rst_n_i, .prog_mode_o, .op_pending_flag_o, .run_o,
  .flash_wr_o, .ee_wr_o, .erase_all_o
);
`default_nettype wire

/* verification/isp_programmer_model.sv */
/*
  Programmer model: serial master shifting four-byte instructions.
  Assumes a 125 ns link period; the clock stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_programmer_model (
  // Serial link towards the port
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // Clock low from the start
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Shift one instruction, keep bytes seen during bytes 3 and 4
  task automatic xfer(input logic [31:0] cmd, output logic [7:0] b3,
                      output logic [7:0] b4);
    logic [31:0] rx;
    for (int i = 31; i >= 0; i--) begin
      sdi_o = cmd[i];
      #62.5;
      sck_o = 1'b1;
      rx[i] = sdo_i;
      #62.5;
      sck_o = 1'b0;
    end
    // Released line shows the inverse of its last bit
    sdi_o = ~cmd[0];
    b3 = rx[15:8];
    b4 = rx[7:0];
  endtask : xfer
endmodule : isp_programmer_model
`default_nettype wire

/* verification/serial_isp_programming_port_bench.sv */
/*
  Bench for the programming port: refusal, enable, EEPROM, flash page,
  erase and exit. Assumes the programmer model and small memory models.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module serial_isp_programming_port_bench;
  // Shortened busy times, erase longest
  localparam int unsigned FW = 1500;
  localparam int unsigned EW = 1200;
  localparam int unsigned CW = 2000;
  // Clock, resets and link
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic chip_reset_n_i;
  logic sck, sdi, sdo, prog_mode, busy, run, fwr, ewr, erase;
  // Memory ports
  logic [23:0] faddr;
  logic [15:0] fwd, frd;
  logic [11:0] eaddr;
  logic [7:0] ewd, erd, r3, r4;
  logic [7:0] ee_mem [16];
  // Counters and captured page word
  int bad_count = 0;
  int tests_run = 0;
  int wr_seen = 0;
  int ee_seen = 0;
  int er_seen = 0;
  logic [23:0] cap_a;
  logic [15:0] cap_d;
  // Flash reads a pattern of its address, eeprom a small array
  assign frd = faddr[15:0] + {faddr[23:16], 8'h00};
  assign erd = ee_mem[eaddr[3:0]];
  initial forever #2 ref_clk_i = ~ref_clk_i;
  initial for (int k = 0; k < 16; k++) ee_mem[k] = 8'h00;
  // Array updates and write capture
  always @(posedge ref_clk_i) begin
    if (erase) begin
      for (int k = 0; k < 16; k++) ee_mem[k] <= 8'hFF;
      er_seen++;
    end
    if (ewr) begin
      ee_mem[eaddr[3:0]] <= ewd;
      ee_seen++;
    end
    if (fwr) begin
      wr_seen++;
      if (faddr[6:0] == 7'h03) begin
        cap_a = faddr;
        cap_d = fwd;
      end
    end
  end
  serial_isp_programming_port #(.FLASH_PAGE_WAIT(FW),
    .EEPROM_BYTE_WAIT(EW), .CHIP_ERASE_WAIT(CW), .PAGE_WORDS(128)
  ) i_serial_isp_programming_port (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .chip_reset_n_i(chip_reset_n_i), .sck_i(sck),
    .serial_prog_data_in_i(sdi), .serial_prog_data_out_o(sdo),
    .prog_mode_o(prog_mode), .op_pending_flag_o(busy), .run_o(run),
    .flash_wr_o(fwr), .flash_addr_o(faddr), .flash_wdata_o(fwd),
    .flash_rdata_i(frd), .ee_wr_o(ewr), .ee_addr_o(eaddr),
    .ee_wdata_o(ewd), .ee_rdata_i(erd), .erase_all_o(erase));
  isp_programmer_model i_isp_programmer_model (.sck_o(sck), .sdi_o(sdi),
    .sdo_i(sdo));
  // One instruction, then a short gap
  task automatic cmd(input logic [31:0] c);
    i_isp_programmer_model.xfer(c, r3, r4);
    repeat (20) @(posedge ref_clk_i);
  endtask : cmd
  // Poll once, then until idle, bounded
  task automatic poll_idle(output logic first);
    cmd(32'hF0000000);
    first = r4[0];
    for (int n = 0; n < 8 && r4[0] !== 1'b0; n++) cmd(32'hF0000000);
    `CHK("idle", 1'b0, r4[0])
  endtask : poll_idle
  // Writes and reads ignored before enable
  task automatic t_refused();
    chip_reset_n_i <= 1'b0;
    // Settling wait before the first frame, scaled down for the run
    repeat (10) @(posedge ref_clk_i);
    cmd(32'hC0000199);
    `CHK("ee_refused", 0, ee_seen)
    cmd(32'hA0000100);
    `CHK("rd_refused", 8'h00, r4)
    `CHK("mode_off", 1'b0, prog_mode)
  endtask : t_refused
  // Enable echoes its second byte
  task automatic t_enable();
    cmd(32'hAC530000);
    `CHK("echo", 8'h53, r3)
    `CHK("mode_on", 1'b1, prog_mode)
  endtask : t_enable
  // Byte write, busy, rewrite without erase, read back
  task automatic t_eeprom();
    logic b;
    cmd(32'hC0000577);
    poll_idle(b);
    `CHK("ee_busy", 1'b1, b)
    `CHK("ee_seen", 1, ee_seen)
    cmd(32'hC0000588);
    poll_idle(b);
    cmd(32'hA0000500);
    `CHK("ee_rewrite", 8'h88, r4)
  endtask : t_eeprom
  // Page load, page write, reads using the kept extended byte
  task automatic t_flash();
    logic b;
    cmd(32'h4D000100);
    cmd(32'h40000334);
    cmd(32'h48000312);
    cmd(32'h4C020000);
    poll_idle(b);
    `CHK("pg_busy", 1'b1, b)
    `CHK("pg_words", 128, wr_seen)
    `CHK("pg_addr", 24'h010203, cap_a)
    `CHK("pg_data", 16'h1234, cap_d)
    cmd(32'h28123400);
    `CHK("rd_hi", 8'h13, r4)
    cmd(32'h20123400);
    `CHK("rd_lo", 8'h34, r4)
  endtask : t_flash
  // Chip erase fills the EEPROM array with ones
  task automatic t_erase();
    logic b;
    cmd(32'hAC800000);
    poll_idle(b);
    `CHK("er_busy", 1'b1, b)
    `CHK("er_seen", 1, er_seen)
    cmd(32'hA0000500);
    `CHK("er_ff", 8'hFF, r4)
  endtask : t_erase
  // Pin high ends the session, taking it low again allows a new enable
  task automatic t_exit();
    chip_reset_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    `CHK("run", 1'b1, run)
    `CHK("mode_end", 1'b0, prog_mode)
    cmd(32'hAC530000);
    `CHK("no_echo", 8'h00, r3)
    chip_reset_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    cmd(32'hAC530000);
    `CHK("re_echo", 8'h53, r3)
  endtask : t_exit
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    // Pin starts high so the link logic sees a clean hold edge
    chip_reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_refused();
    t_enable();
    t_eeprom();
    t_flash();
    t_erase();
    t_exit();
    end_sim();
  end
  // Watchdog well past the expected run
  initial begin
    #300us;
    bad_count++;
    end_sim();
  end
endmodule : serial_isp_programming_port_bench
`undef CHK
`default_nettype wire
